// *** flash_mode_and_reset_control.sv ***
// command-mode control of a multi-i/o serial flash: continuous read, qpi, nop, soft reset
// Summary of operation
// - capture mode byte of dual/quad io reads
// - field 10 skips next opcode phase
// - other field values exit continuous read
// - other mode byte bits are ignored
// - no opcode decode during continuous read
// - exit command clears continuous read and qpi
// - qpi enter command switches when quad set
// - qpi enter ignored while quad bit clear
// - disable command in qpi leaves qpi
// - clearing quad bit leaves qpi
// - disable command also ends continuous read
// - nop only cancels pending reset arm
// - nop ignores io lines three to one in serial mode
// - reset only directly after reset arm
// - soft reset restores power-on defaults, except the last opcode register and the power-up counter
// - other command after arm cancels it
// - soft reset aborts program or erase
// - parameter table advertises wrap read support
`timescale 1ns/1ps
`include "flash_mode_regs.svh"
module flash_mode_and_reset_control #(
  parameter int ADDR_CLOCKS_DUAL = 12,
  parameter int ADDR_CLOCKS_QUAD = 6
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // flash link pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  io_in,
  // device state
  input  wire logic        busy_program,
  output logic             soft_reset_pulse,
  output logic             abort_pulse,
  output logic             cont_read_active,
  output logic             qpi_active,
  output logic             reset_armed
);
  localparam int POWER_UP_CYCLES = `POWER_UP_WAIT_US * `CLK_MHZ;
  // link sampling
  logic [1:0] cs_sync_r, sclk_sync_r;
  logic [3:0] io_s1_r, io_s2_r;
  logic       sclk_d_r, cs_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_sync_r   <= 2'h3;
      sclk_sync_r <= 2'h0;
      io_s1_r     <= 4'h0;
      io_s2_r     <= 4'h0;
      sclk_d_r    <= 1'b0;
      cs_d_r      <= 1'b1;
    end else begin
      cs_sync_r   <= {cs_sync_r[0], cs_n};
      sclk_sync_r <= {sclk_sync_r[0], sclk};
      io_s1_r     <= io_in;
      io_s2_r     <= io_s1_r;
      sclk_d_r    <= sclk_sync_r[1];
      cs_d_r      <= cs_sync_r[1];
    end
  end
  wire cs_low    = ~cs_sync_r[1];
  wire frame_end = cs_sync_r[1] & ~cs_d_r;
  wire sclk_rise = sclk_sync_r[1] & ~sclk_d_r;
  // software-visible control
  logic        quad_enable_bit_r;
  logic [7:0]  read_mode_byte_r;
  logic [7:0]  last_op_r;
  logic [15:0] power_cnt_r;
  // link decode
  flash_mode_pkg::link_state_t st_r;
  logic [7:0] shift_r;
  logic [3:0] bitcnt_r;
  logic       quad_read_r;
  logic       cmd_done;
  logic [7:0] cmd_op;
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [3:0] io,
                                          input logic [2:0] width);
    if (width == 3'd4)
      shift_in = {v[3:0], io};
    else if (width == 3'd2)
      shift_in = {v[5:0], io[1:0]};
    else
      shift_in = {v[6:0], io[0]};
  endfunction
  logic [2:0] op_width;
  logic [2:0] data_width;
  always_comb begin
    op_width   = qpi_active ? 3'd4 : 3'd1;
    data_width = (quad_read_r || qpi_active) ? 3'd4 : 3'd2;
  end
  wire [7:0] op_shift  = shift_in(shift_r, io_s2_r, op_width);
  wire [7:0] dat_shift = shift_in(shift_r, io_s2_r, data_width);
  wire [3:0] op_clocks = qpi_active ? 4'd2 : 4'd8;
  wire [3:0] addr_clocks = quad_read_r ? 4'(ADDR_CLOCKS_QUAD) : 4'(ADDR_CLOCKS_DUAL);
  wire [3:0] mode_clocks = data_width == 3'd4 ? 4'd2 : 4'd4;
  wire powered = (power_cnt_r == 16'(POWER_UP_CYCLES));
  always_comb begin
    cmd_done = 1'b0;
    cmd_op   = op_shift;
    if (st_r == flash_mode_pkg::ST_OP && sclk_rise && cs_low && bitcnt_r == op_clocks - 4'd1)
      cmd_done = 1'b1;
  end
  // the nop opcode checks only io0 in serial mode; io3..1 are synchronised but never shifted in there
  wire is_read = (cmd_op == `OP_DUAL_IO_READ) || (cmd_op == `OP_QUAD_IO_READ);
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset_pulse) begin
      st_r        <= flash_mode_pkg::ST_IDLE;
      shift_r     <= 8'h00;
      bitcnt_r    <= 4'h0;
      quad_read_r <= 1'b0;
    end else if (frame_end) begin
      st_r     <= flash_mode_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
    end else if (st_r == flash_mode_pkg::ST_IDLE && cs_low) begin
      // continuous read starts straight at the address
      st_r     <= cont_read_active ? flash_mode_pkg::ST_ADDR : flash_mode_pkg::ST_OP;
      bitcnt_r <= 4'h0;
    end else if (sclk_rise && cs_low) begin
      unique case (st_r)
        flash_mode_pkg::ST_OP: begin
          shift_r  <= op_shift;
          bitcnt_r <= bitcnt_r + 4'd1;
          if (cmd_done) begin
            bitcnt_r <= 4'h0;
            if (is_read && powered) begin
              st_r        <= flash_mode_pkg::ST_ADDR;
              quad_read_r <= (cmd_op == `OP_QUAD_IO_READ);
            end else begin
              st_r <= flash_mode_pkg::ST_SKIP;
            end
          end
        end
        flash_mode_pkg::ST_ADDR: begin
          bitcnt_r <= bitcnt_r + 4'd1;
          if (bitcnt_r == addr_clocks - 4'd1) begin
            st_r     <= flash_mode_pkg::ST_MODE;
            bitcnt_r <= 4'h0;
          end
        end
        flash_mode_pkg::ST_MODE: begin
          shift_r  <= dat_shift;
          bitcnt_r <= bitcnt_r + 4'd1;
          if (bitcnt_r == mode_clocks - 4'd1)
            st_r <= flash_mode_pkg::ST_SKIP;
        end
        flash_mode_pkg::ST_SKIP: begin
          bitcnt_r <= 4'h0;
        end
        default: begin
          st_r <= flash_mode_pkg::ST_IDLE;
        end
      endcase
    end
  end
  wire mode_done = (st_r == flash_mode_pkg::ST_MODE) && sclk_rise && cs_low &&
                   (bitcnt_r == mode_clocks - 4'd1);
  wire op_taken  = cmd_done && powered;
  // arm holds only across the very next command
  wire go_reset  = op_taken && cmd_op == `OP_RESET_GO && reset_armed;
  // mode state
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset_pulse) begin
      cont_read_active <= 1'b0;
      read_mode_byte_r <= 8'h00;
    end else if (mode_done) begin
      read_mode_byte_r <= dat_shift;
      // only the continuation field matters
      cont_read_active <= dat_shift[`CONT_FIELD_HI:`CONT_FIELD_LO] == `CONT_FIELD_KEEP;
    end else if (op_taken && cmd_op == `OP_CONT_EXIT) begin
      cont_read_active <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset_pulse) begin
      qpi_active <= 1'b0;
    end else if (!quad_enable_bit_r) begin
      qpi_active <= 1'b0;
    end else if (op_taken && cmd_op == `OP_CONT_EXIT) begin
      qpi_active <= 1'b0;
    end else if (op_taken && cmd_op == `OP_QPI_ENTER) begin
      qpi_active <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset_pulse) begin
      reset_armed <= 1'b0;
    end else if (op_taken) begin
      // nop and any other opcode drop the arm
      reset_armed <= (cmd_op == `OP_RESET_ARM);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_pulse <= 1'b0;
      abort_pulse      <= 1'b0;
    end else begin
      soft_reset_pulse <= go_reset;
      abort_pulse      <= go_reset && busy_program;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_op_r <= 8'h00;
    end else if (op_taken) begin
      last_op_r <= cmd_op;
    end
  end
  // opcodes before the wait are dropped, guarding against a host that ignores it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_cnt_r <= 16'h0000;
    end else if (!powered) begin
      power_cnt_r <= power_cnt_r + 16'h0001;
    end
  end
  // axi4-lite write
  logic        aw_got_r, w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == `REG_CTRL) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset_pulse) begin
      quad_enable_bit_r <= 1'b0;
    end else if (wr_go && aw_addr_r == `REG_CTRL && w_strb_r[0]) begin
      quad_enable_bit_r <= w_data_r[0];
    end
  end
  // axi4-lite read
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    unique case (a)
      `REG_CTRL:      read_mux = {31'h0, quad_enable_bit_r};
      `REG_STATUS:    read_mux = {28'h0, reset_armed, qpi_active, cont_read_active, powered};
      `REG_MODE_BYTE: read_mux = {24'h0, read_mode_byte_r};
      `REG_PARAM:     read_mux = `PARAM_WORD;
      `REG_LAST_OP:   read_mux = {24'h0, last_op_r};
      default:        read_mux = 32'h0000_0000;
    endcase
  endfunction
  wire rd_ok = (s_axi_araddr == `REG_CTRL) || (s_axi_araddr == `REG_STATUS) ||
               (s_axi_araddr == `REG_MODE_BYTE) || (s_axi_araddr == `REG_PARAM) ||
               (s_axi_araddr == `REG_LAST_OP);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_mux(s_axi_araddr);
        s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** flash_mode_assertions.sv ***
// port-level checks for the flash mode control block
`timescale 1ns/1ps
`include "flash_mode_regs.svh"
module flash_mode_assertions (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // axi4-lite
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  // device state
  input logic        soft_reset_pulse,
  input logic        abort_pulse,
  input logic        cont_read_active,
  input logic        qpi_active,
  input logic        reset_armed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  // both halves are latched first, so the answer stands two edges after the handshake
  chk_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rd_go |=> s_axi_rvalid)
    else $error("read answer late");
  chk_param_word: assert property (rd_go && s_axi_araddr == `REG_PARAM |=>
    s_axi_rdata == 32'h6477F99E) else $error("parameter word wrong");
  chk_abort_cause: assert property (abort_pulse |-> soft_reset_pulse)
    else $error("abort without reset");
  chk_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse too long");
  chk_reset_state: assert property (soft_reset_pulse |=>
    !(qpi_active || cont_read_active || reset_armed)) else $error("state kept by reset");
  chk_reset_armed: assert property (soft_reset_pulse |->
    $past(reset_armed) || $past(reset_armed, 2)) else $error("reset without arm");
  // quad bit cleared by a write: qpi has to drop within three cycles
  chk_quad_clear: assert property (wr_go && s_axi_awaddr == `REG_CTRL
    && s_axi_wstrb[0] && !s_axi_wdata[0] |-> ##[1:3] !qpi_active) else $error("qpi kept");
endmodule
bind flash_mode_and_reset_control flash_mode_assertions u_chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .soft_reset_pulse, .abort_pulse,
  .cont_read_active, .qpi_active, .reset_armed);

// *** flash_mode_pkg.sv ***
// types for the flash command-mode control block
package flash_mode_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OP    = 3'b001,
    ST_ADDR  = 3'b011,
    ST_MODE  = 3'b010,
    ST_SKIP  = 3'b110
  } link_state_t;
endpackage

// *** flash_mode_regs.svh ***
// constants for the flash command-mode control block
`ifndef FLASH_MODE_REGS_SVH
`define FLASH_MODE_REGS_SVH
`define OP_DUAL_IO_READ   8'hBB
`define OP_QUAD_IO_READ   8'hEB
`define OP_CONT_EXIT      8'hFF
`define OP_QPI_ENTER      8'h38
`define OP_NOP            8'h00
`define OP_RESET_ARM      8'h66
`define OP_RESET_GO       8'h99
`define OP_SET_WRAP       8'h77
`define CONT_FIELD_HI     5
`define CONT_FIELD_LO     4
`define CONT_FIELD_KEEP   2'h2
`define WRAP_LEN_CODE     8'h64
`define WRAP_OPCODE_CODE  8'h77
`define PARAM_WORD        32'h6477F99E
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_MODE_BYTE     8'h08
`define REG_PARAM         8'h0C
`define REG_LAST_OP       8'h10
`define POWER_UP_WAIT_US  300
`define CLK_MHZ           20
`endif

// *** spi_host_model.sv ***
// behavioural spi host on the flash link pins
`timescale 1ns/1ps
module spi_host_model (
  // link pins
  output logic       cs_n,
  output logic       sclk,
  output logic [3:0] io
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io   = 4'h5;
  end
  task automatic open_f();
    cs_n = 1'b0;
    #200;
  endtask
  // n clocks of w lanes, msb first; idle lanes toggle so no stale level helps
  task automatic shift(input logic [31:0] v, input int n, input int w);
    for (int i = n - 1; i >= 0; i--) begin
      io = ~io;
      for (int b = 0; b < w; b++) io[b] = v[i * w + b];
      #200;
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
    end
  endtask
  // clock parked low between frames
  task automatic close_f();
    #200;
    cs_n = 1'b1;
    io   = ~io;
    #1000;
  endtask
endmodule

// *** tb_top.sv ***
// self-checking bench for the flash mode control block
`timescale 1ns/1ps
`include "flash_mode_regs.svh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        busy_program = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdat, rsp, ex;
  logic        cs_n, sclk, soft_reset_pulse, abort_pulse, cont_read_active;
  logic        qpi_active, reset_armed;
  logic [3:0]  io_in;
  logic [7:0]  m;
  logic [23:0] a;
  int          mismatches = 0, checks = 0, nrst = 0, nab = 0, n, w;
  integer      seed = 32'h72B3CFE9;
  flash_mode_and_reset_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cs_n,
    .sclk, .io_in, .busy_program, .soft_reset_pulse, .abort_pulse, .cont_read_active,
    .qpi_active, .reset_armed);
  spi_host_model u_host (.cs_n, .sclk, .io(io_in));
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (soft_reset_pulse === 1'b1) nrst++;
    if (abort_pulse === 1'b1) nab++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrreg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = {30'h00000000, s_axi_bresp};
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp  = {30'h00000000, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic q);
    u_host.open_f();
    if (q) u_host.shift({24'h000000, c}, 2, 4);
    else u_host.shift({24'h000000, c}, 8, 1);
    u_host.close_f();
  endtask
  task automatic st(input logic q, input logic c, input logic r);
    rdreg(`REG_STATUS);
    chk(rdat, {28'h0000000, r, q, c, 1'b1});
    chk({29'h00000000, reset_armed, qpi_active, cont_read_active}, {29'h00000000, r, q, c});
  endtask
  function automatic logic keep(input logic [7:0] b);
    return b[5:4] == 2'h2;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdreg(`REG_PARAM);
    chk(rdat, 32'h6477F99E);
    rdreg(8'h14);
    chk(rsp, 32'h00000002);
    wrreg(`REG_STATUS, 32'h00000001);
    chk(rsp, 32'h00000002);
    repeat (6100) @(posedge aclk);
    st(0, 0, 0);
    cmd(8'hFF, 0);
    cmd(8'h38, 0);
    st(0, 0, 0);
    wrreg(`REG_CTRL, 32'h00000001);
    cmd(8'h38, 0);
    st(1, 0, 0);
    cmd(8'h00, 1);
    st(1, 0, 0);
    cmd(8'hFF, 1);
    st(0, 0, 0);
    cmd(8'h38, 0);
    wrreg(`REG_CTRL, 32'h00000000);
    st(0, 0, 0);
    cmd(8'h66, 0);
    cmd(8'h00, 0);
    st(0, 0, 0);
    cmd(8'h99, 0);
    chk(nrst, 0);
    rdreg(`REG_LAST_OP);
    chk(rdat, 32'h00000099);
    wrreg(`REG_CTRL, 32'h00000001);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      busy_program <= i[0];
      cmd(8'h66, 0);
      st(0, 0, 1);
      cmd(8'h99, 0);
      chk(nrst, i + 1);
      chk(nab, i);
    end
    busy_program <= 1'b0;
    rdreg(`REG_CTRL);
    chk(rdat, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      m = $random(seed);
      a = $random(seed);
      if (i < 2) m[5:4] = 2'h2;
      n = i[0] ? 16 : 8;
      w = i[0] ? 2 : 4;
      u_host.open_f();
      u_host.shift(i[0] ? 32'h000000BB : 32'h000000EB, 8, 1);
      u_host.shift({8'h00, a}, 24 / w, w);
      u_host.shift({24'h000000, m}, 8 / w, w);
      u_host.close_f();
      rdreg(`REG_MODE_BYTE);
      chk(rdat, {24'h000000, m});
      st(0, keep(m), 0);
      if (keep(m)) begin
        // no opcode phase: 66 lands as address and mode byte
        u_host.open_f();
        u_host.shift(32'h66666666, n, w);
        u_host.close_f();
        rdreg(`REG_MODE_BYTE);
        chk(rdat, 32'h00000066);
        st(0, 1, 0);
        ex = i[0] ? 32'h00000000 : 32'hFFFFFFFF;
        u_host.open_f();
        u_host.shift(ex, n, w);
        u_host.close_f();
        st(0, 0, 0);
      end
    end
    finish_test();
  end
endmodule
